//--- design/quad_phase_decoder_pkg.sv
// Purpose: shared constants for the scroll wheel quadrature decoder
// Assumes: classic wishbone, 32-bit data, register index = byte address / 4
// Notes: all offsets below are register indices
package quad_phase_decoder_pkg;
    // clocking
    localparam int SYS_CLK_HZ = 125_000_000;
    localparam int SLOW_CLK_HZ = 32_000;
    localparam int TICK_DIV = SYS_CLK_HZ / SLOW_CLK_HZ;

    // register indices
    localparam logic [7:0] IDX_COUNT_SNAPSHOT = 8'hd0;
    localparam logic [7:0] IDX_FILTER_CFG = 8'hd1;
    localparam logic [7:0] IDX_PHASE_A_SEL = 8'hd2;
    localparam logic [7:0] IDX_PHASE_B_SEL = 8'hd3;
    localparam logic [7:0] IDX_DECODER_RESET = 8'hd6;
    localparam logic [7:0] IDX_COUNT_MODE = 8'hd7;
    localparam logic [7:0] IDX_SNAPSHOT_LOAD = 8'hd8;

    // field positions in filter_polarity_shuttle_cfg
    localparam int CFG_WINDOW_LSB = 0;
    localparam int CFG_WINDOW_W = 3;
    localparam int CFG_POLARITY_BIT = 4;
    localparam int CFG_SHUTTLE_BIT = 5;

    // field widths
    localparam int PAD_SEL_W = 3;
    localparam int PAD_COUNT = 8;
    localparam int FILTER_CNT_W = 10;

    // reset values
    localparam logic [7:0] RST_FILTER_CFG = 8'h02;
    localparam logic [2:0] RST_PHASE_A_SEL = 3'h0;
    localparam logic [2:0] RST_PHASE_B_SEL = 3'h1;
    localparam logic RST_COUNT_MODE = 1'b0;

    // jitter threshold is this many times 2^(window+1) slow ticks
    localparam logic [FILTER_CNT_W-1:0] JITTER_MULT = 10'h003;

    // counting modes
    typedef enum logic {MODE_COMMON, MODE_DOUBLE} count_mode_t;
endpackage

//--- design/phase_filter_if.sv
// Purpose: carries one phase between the decoder core and its glitch filter
// Assumes: single clock domain
// Notes: clean is idle-low regardless of pad polarity
`timescale 1ns/1ps
`default_nettype none
interface phase_filter_if;
    logic raw;
    logic idle_high;
    logic tick;
    logic [2:0] window;
    logic clean;
    modport filter (input raw, input idle_high, input tick, input window, output clean);
    modport user (output raw, output idle_high, output tick, output window, input clean);
endinterface
`default_nettype wire

//--- design/phase_glitch_filter.sv
// Purpose: debounce one phase into a clean square wave
// Assumes: tick is a one-cycle pulse at the slow filter rate
// Notes: output only follows input after it stood for the full threshold
`timescale 1ns/1ps
`default_nettype none
module phase_glitch_filter
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // phase link
    phase_filter_if.filter ph
);
    logic [quad_phase_decoder_pkg::FILTER_CNT_W-1:0] stable_cnt;
    logic [quad_phase_decoder_pkg::FILTER_CNT_W-1:0] threshold;
    logic [3:0] shift;
    logic level;
    logic clean;

    // normalise so that idle reads low
    assign level = ph.raw ^ ph.idle_high;
    assign shift = {1'b0, ph.window} + 4'h1;
    assign threshold = quad_phase_decoder_pkg::JITTER_MULT << shift;
    assign ph.clean = clean;

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            stable_cnt <= '0;
            clean <= 1'b0;
        end
        else if (level == clean)
        begin
            stable_cnt <= '0;
        end
        else if (ph.tick)
        begin
            if (stable_cnt + 10'h001 >= threshold)
            begin
                clean <= level;
                stable_cnt <= '0;
            end
            else
            begin
                stable_cnt <= stable_cnt + 10'h001;
            end
        end
    end
endmodule
`default_nettype wire

//--- design/quadrature_wheel_decoder.sv
// Purpose: two-phase scroll wheel decoder with byte registers on wishbone
// Assumes: pad inputs synchronous to sys_clk; wishbone classic slave
// Notes: register byte address is four times the register index
`timescale 1ns/1ps
`default_nettype none

module quadrature_wheel_decoder
#(
    parameter int ADDR_W = 10,
    parameter int TICK_DIV = quad_phase_decoder_pkg::TICK_DIV
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // candidate pads for the two phases
    input wire logic [quad_phase_decoder_pkg::PAD_COUNT-1:0] pad_in
);
    generate
        if (ADDR_W < 10)
        begin : g_bad_addr
            $error("address must be at least 10 bits to reach the register block");
        end
        if (TICK_DIV < 1 || TICK_DIV > 4096)
        begin : g_bad_div
            $error("tick divider must be between 1 and 4096");
        end
    endgenerate

    // pick one pad by its selector
    function automatic logic pick_pad(input logic [7:0] pads, input logic [2:0] sel);
        pick_pad = pads[sel];
    endfunction

    phase_filter_if phase_a_if();
    phase_filter_if phase_b_if();

    // bus decode
    logic [7:0] reg_index;
    logic bus_take;
    logic bus_write;
    logic bus_read;
    logic upper_zero;

    // configuration registers
    logic [2:0] filter_window;
    logic idle_high;
    logic shuttle_en;
    logic [2:0] phase_a_sel;
    logic [2:0] phase_b_sel;
    quad_phase_decoder_pkg::count_mode_t count_mode;
    logic load_req;
    logic [7:0] count_snapshot;

    // decoder state
    logic [11:0] tick_cnt;
    logic tick;
    logic prev_a;
    logic prev_b;
    logic last_pulse_b;
    logic pulse_pending;
    logic [7:0] running_step_count;
    logic edge_a;
    logic edge_b;
    logic step_up;
    logic step_down;
    logic clear_counter;
    logic [31:0] next_rdata;

    assign upper_zero = (wb_adr_i[ADDR_W-1:2] >> 8) == '0;
    assign reg_index = wb_adr_i[9:2];
    assign bus_take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_write = bus_take && wb_we_i && wb_sel_i[0] && upper_zero;
    assign bus_read = bus_take && !wb_we_i && upper_zero;
    assign clear_counter = bus_write && reg_index == quad_phase_decoder_pkg::IDX_DECODER_RESET
        && wb_dat_i[0];

    // slow tick for the glitch filters
    always_ff @(posedge sys_clk)
    begin
        tick <= reset_n && tick_cnt == 12'(TICK_DIV - 1);
        if (!reset_n || tick_cnt == 12'(TICK_DIV - 1))
        begin
            tick_cnt <= '0;
        end
        else
        begin
            tick_cnt <= tick_cnt + 12'h001;
        end
    end

    // pad routing into the filters
    assign phase_a_if.raw = pick_pad(pad_in, phase_a_sel);
    assign phase_b_if.raw = pick_pad(pad_in, phase_b_sel);
    assign phase_a_if.idle_high = idle_high;
    assign phase_b_if.idle_high = idle_high;
    assign phase_a_if.tick = tick;
    assign phase_b_if.tick = tick;
    assign phase_a_if.window = filter_window;
    assign phase_b_if.window = filter_window;

    phase_glitch_filter u_filter_a
    (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .ph(phase_a_if.filter)
    );

    phase_glitch_filter u_filter_b
    (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .ph(phase_b_if.filter)
    );

    // edge detection on the clean square waves
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            prev_a <= 1'b0;
            prev_b <= 1'b0;
        end
        else
        begin
            prev_a <= phase_a_if.clean;
            prev_b <= phase_b_if.clean;
        end
    end

    assign edge_a = phase_a_if.clean != prev_a;
    assign edge_b = phase_b_if.clean != prev_b;

    // shuttle mode: a lone pulse waits for the other phase, and each pair counts once;
    // without the restart a steady rotation would alternate up and down
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            last_pulse_b <= 1'b1;
            pulse_pending <= 1'b0;
        end
        else if (!shuttle_en || step_up || step_down)
        begin
            pulse_pending <= 1'b0;
        end
        else if (edge_a && phase_a_if.clean)
        begin
            last_pulse_b <= 1'b0;
            pulse_pending <= 1'b1;
        end
        else if (edge_b && phase_b_if.clean)
        begin
            last_pulse_b <= 1'b1;
            pulse_pending <= 1'b1;
        end
    end

    // direction and step decision
    always_comb
    begin
        step_up = 1'b0;
        step_down = 1'b0;
        if (shuttle_en)
        begin
            // a rise pairs with the pending pulse of the other phase
            step_up = pulse_pending && !last_pulse_b && edge_b && phase_b_if.clean && !edge_a;
            step_down = pulse_pending && last_pulse_b && edge_a && phase_a_if.clean && !edge_b;
        end
        else if (edge_a != edge_b)
        begin
            if (count_mode == quad_phase_decoder_pkg::MODE_DOUBLE)
            begin
                // every single edge counts; a edge with phases apart means a leads
                step_up = (phase_a_if.clean ^ phase_b_if.clean) == edge_a;
                step_down = !step_up;
            end
            else if (phase_a_if.clean == phase_b_if.clean)
            begin
                // count when the second phase catches up to the first
                step_up = edge_b;
                step_down = edge_a;
            end
        end
    end

    // internal counter, never on the bus
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            running_step_count <= '0;
        end
        else if (clear_counter)
        begin
            running_step_count <= '0;
        end
        else if (step_up)
        begin
            running_step_count <= running_step_count + 8'h01;
        end
        else if (step_down)
        begin
            running_step_count <= running_step_count - 8'h01;
        end
    end

    // load request sets on write and clears after the copy
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            load_req <= 1'b0;
        end
        else if (bus_write && reg_index == quad_phase_decoder_pkg::IDX_SNAPSHOT_LOAD
            && wb_dat_i[0])
        begin
            load_req <= 1'b1;
        end
        else if (load_req)
        begin
            load_req <= 1'b0;
        end
    end

    // snapshot: copy wins over a simultaneous read-clear
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            count_snapshot <= '0;
        end
        else if (load_req)
        begin
            count_snapshot <= running_step_count;
        end
        else if (bus_read && reg_index == quad_phase_decoder_pkg::IDX_COUNT_SNAPSHOT)
        begin
            count_snapshot <= '0;
        end
    end

    // configuration writes
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            filter_window <= quad_phase_decoder_pkg::RST_FILTER_CFG[2:0];
            idle_high <= quad_phase_decoder_pkg::RST_FILTER_CFG[4];
            shuttle_en <= quad_phase_decoder_pkg::RST_FILTER_CFG[5];
            phase_a_sel <= quad_phase_decoder_pkg::RST_PHASE_A_SEL;
            phase_b_sel <= quad_phase_decoder_pkg::RST_PHASE_B_SEL;
            count_mode <= quad_phase_decoder_pkg::count_mode_t'(
                quad_phase_decoder_pkg::RST_COUNT_MODE);
        end
        else if (bus_write)
        begin
            case (reg_index)
                quad_phase_decoder_pkg::IDX_FILTER_CFG:
                begin
                    filter_window <= wb_dat_i[quad_phase_decoder_pkg::CFG_WINDOW_LSB +: 3];
                    idle_high <= wb_dat_i[quad_phase_decoder_pkg::CFG_POLARITY_BIT];
                    shuttle_en <= wb_dat_i[quad_phase_decoder_pkg::CFG_SHUTTLE_BIT];
                end
                quad_phase_decoder_pkg::IDX_PHASE_A_SEL: phase_a_sel <= wb_dat_i[2:0];
                quad_phase_decoder_pkg::IDX_PHASE_B_SEL: phase_b_sel <= wb_dat_i[2:0];
                quad_phase_decoder_pkg::IDX_COUNT_MODE:
                    count_mode <= quad_phase_decoder_pkg::count_mode_t'(wb_dat_i[0]);
                default: ;
            endcase
        end
    end

    // read mux; unmapped indices read zero
    always_comb
    begin
        next_rdata = '0;
        if (upper_zero)
        begin
            case (reg_index)
                quad_phase_decoder_pkg::IDX_COUNT_SNAPSHOT: next_rdata[7:0] = count_snapshot;
                quad_phase_decoder_pkg::IDX_FILTER_CFG:
                    next_rdata[7:0] = {2'h0, shuttle_en, idle_high, 1'b0, filter_window};
                quad_phase_decoder_pkg::IDX_PHASE_A_SEL: next_rdata[7:0] = {5'h00, phase_a_sel};
                quad_phase_decoder_pkg::IDX_PHASE_B_SEL: next_rdata[7:0] = {5'h00, phase_b_sel};
                quad_phase_decoder_pkg::IDX_COUNT_MODE: next_rdata[7:0] = {7'h00, count_mode};
                quad_phase_decoder_pkg::IDX_SNAPSHOT_LOAD: next_rdata[7:0] = {7'h00, load_req};
                default: next_rdata = '0;
            endcase
        end
    end

    // one-wait-state acknowledge
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= bus_take;
            if (bus_take && !wb_we_i)
            begin
                wb_dat_o <= next_rdata;
            end
        end
    end
endmodule
`default_nettype wire

//--- sim/wheel_encoder_model.sv
// Purpose: rotary wheel encoder driving the decoder's candidate pads
// Assumes: called by the bench just after a rising edge of sys_clk
// Notes: pads that carry no phase toggle every cycle
`timescale 1ns/1ps
`default_nettype none
module wheel_encoder_model
(
    // clock
    input wire logic sys_clk,
    // pad levels seen by the decoder
    output logic [quad_phase_decoder_pkg::PAD_COUNT-1:0] pad_in
);
    logic a = 1'b0;
    logic b = 1'b0;
    logic idle_high = 1'b0;
    logic [2:0] sel_a = 3'h0;
    logic [2:0] sel_b = 3'h1;
    logic [quad_phase_decoder_pkg::PAD_COUNT-1:0] noise = 8'h5a;

    // a wrong pad choice sees only fast toggling, never a phase
    always_ff @(posedge sys_clk)
        noise <= ~noise;

    // phase pads are plain inputs, never driven by the decoder
    always_comb
    begin
        pad_in = noise;
        pad_in[sel_a] = a ^ idle_high;
        pad_in[sel_b] = b ^ idle_high;
    end

    task automatic route(input logic [2:0] sa, input logic [2:0] sb, input logic pol);
        sel_a <= sa;
        sel_b <= sb;
        idle_high <= pol;
    endtask

    task automatic phase(input logic na, input logic nb, input int cycles);
        a <= na;
        b <= nb;
        repeat (cycles) @(posedge sys_clk);
    endtask

    // every level is held 20 cycles, past the jitter threshold for windows 0 and 1
    task automatic turn(input int steps, input logic fwd);
        repeat (steps)
        begin
            phase(fwd, !fwd, 20);
            phase(1'b1, 1'b1, 20);
            phase(!fwd, fwd, 20);
            phase(1'b0, 1'b0, 20);
        end
    endtask

    // shuttle wheel: one phase pulses, then the other, never both high at once
    task automatic shuttle(input int steps, input logic fwd);
        repeat (steps)
        begin
            phase(fwd, !fwd, 20);
            phase(1'b0, 1'b0, 20);
            phase(!fwd, fwd, 20);
            phase(1'b0, 1'b0, 20);
        end
    endtask
endmodule
`default_nettype wire

//--- sim/quadrature_wheel_decoder_props.sv
// Purpose: bus-side properties of the wheel decoder
// Assumes: bound to the top module, one clock domain
// Notes: shadows follow acked writes with byte lane 0 enabled
`timescale 1ns/1ps
`default_nettype none
module quadrature_wheel_decoder_props
#(
    parameter int ADDR_W = 10
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // pads
    input wire logic [quad_phase_decoder_pkg::PAD_COUNT-1:0] pad_in
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    logic wr_ack;
    logic rd_ack;
    logic snap_read;
    logic [2:0] sh_a;
    logic [2:0] sh_b;
    logic sh_mode;
    logic [7:0] sh_cfg;

    assign wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];
    assign rd_ack = wb_ack_o && !wb_we_i;

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            snap_read <= 1'b0;
            sh_a <= 3'h0;
            sh_b <= 3'h1;
            sh_mode <= 1'b0;
            sh_cfg <= 8'h02;
        end
        else if (wr_ack)
        begin
            if (wb_adr_i == ADDR_W'(10'h360) && wb_dat_i[0])
                snap_read <= 1'b0;
            if (wb_adr_i == ADDR_W'(10'h348))
                sh_a <= wb_dat_i[2:0];
            if (wb_adr_i == ADDR_W'(10'h34c))
                sh_b <= wb_dat_i[2:0];
            if (wb_adr_i == ADDR_W'(10'h35c))
                sh_mode <= wb_dat_i[0];
            if (wb_adr_i == ADDR_W'(10'h344))
                sh_cfg <= wb_dat_i[7:0];
        end
        else if (rd_ack && wb_adr_i == ADDR_W'(10'h340))
            snap_read <= 1'b1;
    end

    a_ack_pulse: assert property ($rose(wb_ack_o) |=> $fell(wb_ack_o))
        else $error("ack held longer than one cycle");
    a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##1 wb_ack_o)
        else $error("request not answered in one cycle");
    a_snap_cleared: assert property (rd_ack && wb_adr_i == ADDR_W'(10'h340) && snap_read
        |-> wb_dat_o[7:0] == 8'h00)
        else $error("snapshot not cleared by read or refreshed without load");
    a_load_done: assert property (rd_ack && wb_adr_i == ADDR_W'(10'h360) |-> !wb_dat_o[0])
        else $error("load bit still set at readback");
    a_rst_ctrl_zero: assert property (rd_ack && wb_adr_i == ADDR_W'(10'h358) |-> !wb_dat_o[0])
        else $error("reset control bit did not clear itself");
    a_pad_a_back: assert property (rd_ack && wb_adr_i == ADDR_W'(10'h348)
        |-> wb_dat_o[2:0] == sh_a)
        else $error("phase a pad selection lost");
    a_pad_b_back: assert property (rd_ack && wb_adr_i == ADDR_W'(10'h34c)
        |-> wb_dat_o[2:0] == sh_b)
        else $error("phase b pad selection lost");
    a_mode_back: assert property (rd_ack && wb_adr_i == ADDR_W'(10'h35c)
        |-> wb_dat_o[0] == sh_mode)
        else $error("count mode bit lost");
    a_cfg_back: assert property (rd_ack && wb_adr_i == ADDR_W'(10'h344)
        |-> (wb_dat_o[7:0] & 8'h37) == (sh_cfg & 8'h37))
        else $error("filter configuration lost");
endmodule
`default_nettype wire

//--- sim/tb_quadrature_wheel_decoder.sv
// Purpose: register-level test of the wheel decoder with an encoder model
// Assumes: one filter tick per clock, so window 0 is 6 cycles
// Notes: counts are 8 bit and wrap below zero
`timescale 1ns/1ps
`default_nettype none
module tb_quadrature_wheel_decoder;
    logic sys_clk;
    logic reset_n;
    logic wb_cyc;
    logic wb_stb;
    logic wb_we;
    logic [9:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_wdat;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic [quad_phase_decoder_pkg::PAD_COUNT-1:0] pad_in;
    logic [31:0] rd;
    int n_fail;
    int n_compared;
    logic [9:0] addrs [7] = '{10'h340, 10'h344, 10'h348, 10'h34c, 10'h358, 10'h35c, 10'h360};
    logic [7:0] rst_vals [7] = '{8'h00, 8'h02, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};

    quadrature_wheel_decoder #(.ADDR_W(10), .TICK_DIV(1)) quadrature_wheel_decoder_i (
        .sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .pad_in(pad_in));
    wheel_encoder_model wheel_encoder_model_i (.sys_clk(sys_clk), .pad_in(pad_in));

    task automatic report_and_stop();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            $display("mismatch %s expected %h seen %h", what, exp, seen);
            n_fail++;
        end
    endtask

    task automatic wb_cycle(input logic [9:0] adr, input logic we, input logic [7:0] dat,
                            input logic [3:0] sel, output logic [31:0] data);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= sel;
        wb_wdat <= {24'h000000, dat};
        @(posedge sys_clk);
        while (wb_ack !== 1'b1 && n < 50)
        begin
            @(posedge sys_clk);
            n++;
        end
        data = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n >= 50)
        begin
            n_fail++;
            report_and_stop();
        end
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [9:0] adr, input logic [7:0] dat);
        logic [31:0] d;
        wb_cycle(adr, 1'b1, dat, 4'hf, d);
    endtask

    task automatic rd_chk(input logic [9:0] adr, input logic [7:0] exp);
        logic [31:0] d;
        wb_cycle(adr, 1'b0, 8'h00, 4'hf, d);
        check($sformatf("register %h", adr), d, {24'h000000, exp});
    endtask

    // load, confirm the load bit cleared, read, then read again
    task automatic check_count(input logic [7:0] exp);
        wr(10'h360, 8'h01);
        rd_chk(10'h360, 8'h00);
        rd_chk(10'h340, exp);
        rd_chk(10'h340, 8'h00);
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial
    begin
        n_fail = 0;
        n_compared = 0;
        reset_n = 1'b0;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 10'h000;
        wb_sel = 4'h0;
        wb_wdat = 32'h00000000;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        foreach (addrs[i])
            rd_chk(addrs[i], rst_vals[i]);
        wr(10'h3fc, 8'hff);
        rd_chk(10'h3fc, 8'h00);
        wb_cycle(10'h35c, 1'b1, 8'h01, 4'h0, rd);
        rd_chk(10'h35c, 8'h00);
        wr(10'h344, 8'h00);
        wr(10'h358, 8'h01);
        wheel_encoder_model_i.turn(3, 1'b1);
        rd_chk(10'h340, 8'h00);
        check_count(8'h06);
        wheel_encoder_model_i.turn(1, 1'b0);
        check_count(8'h04);
        wr(10'h358, 8'h01);
        check_count(8'h00);
        wr(10'h35c, 8'h01);
        rd_chk(10'h35c, 8'h01);
        wheel_encoder_model_i.turn(2, 1'b1);
        wheel_encoder_model_i.turn(3, 1'b0);
        check_count(8'hfc);
        wr(10'h348, 8'h05);
        wr(10'h34c, 8'h07);
        rd_chk(10'h34c, 8'h07);
        wheel_encoder_model_i.route(3'h5, 3'h7, 1'b0);
        wr(10'h358, 8'h01);
        wheel_encoder_model_i.turn(1, 1'b1);
        check_count(8'h04);
        wheel_encoder_model_i.route(3'h5, 3'h7, 1'b1);
        wr(10'h344, 8'h10);
        wr(10'h358, 8'h01);
        wheel_encoder_model_i.turn(1, 1'b0);
        check_count(8'hfc);
        wheel_encoder_model_i.route(3'h5, 3'h7, 1'b0);
        wr(10'h344, 8'h01);
        wr(10'h358, 8'h01);
        wheel_encoder_model_i.phase(1'b1, 1'b0, 8);
        check_count(8'h00);
        repeat (20) @(posedge sys_clk);
        check_count(8'h01);
        wheel_encoder_model_i.phase(1'b0, 1'b0, 20);
        check_count(8'h00);
        // a pulse shorter than the window must never reach the counter
        wheel_encoder_model_i.phase(1'b0, 1'b1, 8);
        wheel_encoder_model_i.phase(1'b0, 1'b0, 20);
        check_count(8'h00);
        wr(10'h344, 8'h21);
        rd_chk(10'h344, 8'h21);
        wr(10'h35c, 8'h00);
        wr(10'h358, 8'h01);
        wheel_encoder_model_i.shuttle(2, 1'b1);
        wheel_encoder_model_i.shuttle(1, 1'b0);
        check_count(8'h01);
        report_and_stop();
    end
endmodule

bind quadrature_wheel_decoder quadrature_wheel_decoder_props #(.ADDR_W(ADDR_W)) props_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_in(pad_in));
`default_nettype wire
